/* design/fbso_station_config.sv */
// Behaviour
// - link refresh period kept between 1.1 and 141 ms
// - selector 0 legacy v1, 1 plain v1 single
// - 12/14/18 give v2 double/quad/octuple
// - 24/28 only on variants with extension feature
// - 100-range codes give controller-function variants
// - legacy: simultaneous set/instruction requests, execute one
// - legacy: instruction word upper byte is extension
// - selector change applies only at inverter reset or at an accepted error reset
// - error reset acts only during fault alarm
// - history clear erases all eight fault records
// - one station, number 1 to 64
// - legacy: instruction code upper byte reads zero
`default_nettype none
module fbso_station_config #(
  parameter int unsigned MIN_CYC = fbso_pkg::REFRESH_MIN_CYC,
  parameter int unsigned MAX_CYC = fbso_pkg::REFRESH_MAX_CYC,
  parameter bit FEATURE_EXT = 1'b0,
  parameter int unsigned CNT_W = $clog2(MAX_CYC + 1)
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  input wire logic inverter_reset_pin_in,
  input wire logic fault_alarm_pin_in,
  input wire logic [7:0] fault_code_in,
  input wire logic link_refresh_in,
  input wire logic freq_set_volatile_request_in,
  input wire logic freq_set_nonvolatile_request_in,
  input wire logic instruction_execute_request_in,
  input wire logic [15:0] instruction_code_word_in,
  input wire logic error_reset_request_in,
  input wire logic fault_hist_clear_in,
  output logic freq_set_volatile_exec_out,
  output logic freq_set_nonvolatile_exec_out,
  output logic instruction_exec_out,
  output logic [15:0] instruction_code_out,
  output logic [7:0] link_param_ext_out,
  output logic legacy_mode_out,
  output logic plc_mode_out,
  output logic version2_out,
  output logic [1:0] occupancy_out,
  output logic [6:0] station_out,
  output logic device_reset_out,
  output logic fault_active_out
);
  localparam logic [CNT_W-1:0] MIN_C = CNT_W'(MIN_CYC);
  localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYC);

  // ----------------------------------------------------------------
  // pin synchronisers and fault record store
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic inv_rst_s;
  logic alarm_s;
  logic [7:0] fault_rd;
  logic [3:0] fault_cnt;
  logic [2:0] fault_idx_q;
  logic [2:0] fault_idx_d;

  fbso_sync3 #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({inverter_reset_pin_in, fault_alarm_pin_in}),
    .sync_out(pins_s)
  );
  assign inv_rst_s = pins_s[1];
  assign alarm_s = pins_s[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] cfg_sel_q, cfg_sel_d;
  logic [6:0] cfg_stn_q, cfg_stn_d;
  logic [7:0] act_sel_q, act_sel_d;
  logic [6:0] act_stn_q, act_stn_d;
  logic [4:0] mode_q, mode_d;
  logic [5:0] irq_stat_q, irq_stat_d;
  logic [5:0] irq_mask_q, irq_mask_d;
  logic [5:0] irq_set;
  logic irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic [4:0] prev_q, prev_d;
  logic inv_prev_q, alarm_prev_q;
  logic fault_q, fault_d;
  logic [2:0] exec_q, exec_d;
  logic [15:0] code_q, code_d;
  logic [7:0] ext_q, ext_d;
  logic rst_pulse_q, rst_pulse_d;
  logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic seen_q, seen_d;
  logic [4:0] rise;
  logic inv_rise, alarm_rise, err_ok, apply_ev, sel_ok;
  logic [5:0] dec;
  logic wr_cfg, wr_stat, wr_mask, wr_idx;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    rise = {error_reset_request_in, fault_hist_clear_in, instruction_execute_request_in,
            freq_set_nonvolatile_request_in, freq_set_volatile_request_in} & ~prev_q;
    prev_d = {error_reset_request_in, fault_hist_clear_in, instruction_execute_request_in,
              freq_set_nonvolatile_request_in, freq_set_volatile_request_in};
    inv_rise = inv_rst_s & ~inv_prev_q;
    alarm_rise = alarm_s & ~alarm_prev_q;
    wr_cfg = reg_wr_in && (reg_addr_in == fbso_pkg::OFF_CFG);
    wr_stat = reg_wr_in && (reg_addr_in == fbso_pkg::OFF_IRQ_STAT);
    wr_mask = reg_wr_in && (reg_addr_in == fbso_pkg::OFF_IRQ_MASK);
    wr_idx = reg_wr_in && (reg_addr_in == fbso_pkg::OFF_FAULT_IDX);
    irq_set = '0;
    err_ok = rise[4] && fault_q;
    fault_d = fault_q;
    if (err_ok) begin
      fault_d = 1'b0;
    end
    if (alarm_rise) begin
      fault_d = 1'b1;
    end
    rst_pulse_d = err_ok;
    irq_set[fbso_pkg::IRQ_ERR_RESET] = err_ok;
    irq_set[fbso_pkg::IRQ_HIST_CLR] = rise[3];
    // software setting is only staged; a reset of the drive picks it up
    cfg_sel_d = wr_cfg ? reg_wdata_in[fbso_pkg::CFG_SEL_LSB +: 8] : cfg_sel_q;
    cfg_stn_d = wr_cfg ? reg_wdata_in[fbso_pkg::CFG_STN_LSB +: 7] : cfg_stn_q;
    irq_set[fbso_pkg::IRQ_PENDING] = wr_cfg &&
      (reg_wdata_in[fbso_pkg::CFG_SEL_LSB +: 8] != act_sel_q ||
       reg_wdata_in[fbso_pkg::CFG_STN_LSB +: 7] != act_stn_q);
    apply_ev = inv_rise || err_ok;
    dec = fbso_pkg::fbso_decode(cfg_sel_q, FEATURE_EXT);
    sel_ok = dec[5] && cfg_stn_q >= fbso_pkg::STN_MIN && cfg_stn_q <= fbso_pkg::STN_MAX;
    act_sel_d = act_sel_q;
    act_stn_d = act_stn_q;
    mode_d = mode_q;
    if (apply_ev) begin
      if (sel_ok) begin
        act_sel_d = cfg_sel_q;
        act_stn_d = cfg_stn_q;
        mode_d = dec[4:0];
      end else begin
        irq_set[fbso_pkg::IRQ_REJECT] = 1'b1;
      end
    end
    exec_d = rise[2:0];
    if (mode_q[4]) begin
      if (rise[0]) begin
        exec_d = 3'h1;
      end else if (rise[1]) begin
        exec_d = 3'h2;
      end
    end
    code_d = code_q;
    ext_d = ext_q;
    if (apply_ev) begin
      // a mode switch must not leave a stale upper byte visible
      code_d = '0;
      ext_d = '0;
    end else if (link_refresh_in) begin
      code_d = mode_q[4] ? {8'h00, instruction_code_word_in[7:0]} : instruction_code_word_in;
      ext_d = mode_q[4] ? instruction_code_word_in[15:8] : 8'h00;
    end
    wd_cnt_d = wd_cnt_q;
    seen_d = seen_q;
    if (link_refresh_in) begin
      irq_set[fbso_pkg::IRQ_FAST] = seen_q && (wd_cnt_q < MIN_C - 1'b1);
      wd_cnt_d = '0;
      seen_d = 1'b1;
    end else if (seen_q) begin
      if (wd_cnt_q == MAX_C - 1'b1) begin
        irq_set[fbso_pkg::IRQ_SLOW] = 1'b1;
        seen_d = 1'b0;
      end
      wd_cnt_d = wd_cnt_q + 1'b1;
    end
    // set beats a write-one clear in the same cycle
    irq_stat_d = (wr_stat ? (irq_stat_q & ~reg_wdata_in[5:0]) : irq_stat_q) | irq_set;
    irq_mask_d = wr_mask ? reg_wdata_in[5:0] : irq_mask_q;
    irq_d = |(irq_stat_d & irq_mask_d);
    fault_idx_d = wr_idx ? reg_wdata_in[2:0] : fault_idx_q;
    rdata_d = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        fbso_pkg::OFF_CFG: rdata_d = {17'h0, cfg_stn_q, cfg_sel_q};
        fbso_pkg::OFF_ACTIVE: rdata_d = {7'h0, fault_q, 3'h0, mode_q, 1'b0, act_stn_q, act_sel_q};
        fbso_pkg::OFF_IRQ_STAT: rdata_d = {26'h0, irq_stat_q};
        fbso_pkg::OFF_IRQ_MASK: rdata_d = {26'h0, irq_mask_q};
        fbso_pkg::OFF_FAULT_CNT: rdata_d = {28'h0, fault_cnt};
        fbso_pkg::OFF_FAULT_IDX: rdata_d = {29'h0, fault_idx_q};
        fbso_pkg::OFF_FAULT_DATA: rdata_d = {24'h0, fault_rd};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_sel_q <= fbso_pkg::SEL_RST;
      cfg_stn_q <= fbso_pkg::STN_RST;
      act_sel_q <= fbso_pkg::SEL_RST;
      act_stn_q <= fbso_pkg::STN_RST;
      mode_q <= fbso_pkg::MODE_RST;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= '0;
      prev_q <= '0;
      inv_prev_q <= 1'b0;
      alarm_prev_q <= 1'b0;
      fault_q <= 1'b0;
      exec_q <= '0;
      code_q <= '0;
      ext_q <= '0;
      rst_pulse_q <= 1'b0;
      wd_cnt_q <= '0;
      seen_q <= 1'b0;
      fault_idx_q <= '0;
    end else begin
      cfg_sel_q <= cfg_sel_d;
      cfg_stn_q <= cfg_stn_d;
      act_sel_q <= act_sel_d;
      act_stn_q <= act_stn_d;
      mode_q <= mode_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      prev_q <= prev_d;
      inv_prev_q <= inv_rst_s;
      alarm_prev_q <= alarm_s;
      fault_q <= fault_d;
      exec_q <= exec_d;
      code_q <= code_d;
      ext_q <= ext_d;
      rst_pulse_q <= rst_pulse_d;
      wd_cnt_q <= wd_cnt_d;
      seen_q <= seen_d;
      fault_idx_q <= fault_idx_d;
    end
  end

  // ----------------------------------------------------------------
  // fault history
  // ----------------------------------------------------------------
  // erase all records
  fbso_fault_mem #(.DEPTH(fbso_pkg::FAULT_DEPTH), .WIDTH(fbso_pkg::FAULT_W)) u_hist (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_in(alarm_rise),
    .wr_data_in(fault_code_in),
    .clear_in(rise[3]),
    .rd_idx_in(fault_idx_q),
    .rd_data_out(fault_rd),
    .count_out(fault_cnt)
  );

  assign reg_rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign freq_set_volatile_exec_out = exec_q[0];
  assign freq_set_nonvolatile_exec_out = exec_q[1];
  assign instruction_exec_out = exec_q[2];
  assign instruction_code_out = code_q;
  assign link_param_ext_out = ext_q;
  assign legacy_mode_out = mode_q[4];
  assign plc_mode_out = mode_q[3];
  assign version2_out = mode_q[2];
  assign occupancy_out = mode_q[1:0];
  assign station_out = act_stn_q;
  assign device_reset_out = rst_pulse_q;
  assign fault_active_out = fault_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_slow_refresh;
    @(posedge clk_in) disable iff (reset_in)
    seen_q && !link_refresh_in && wd_cnt_q == MAX_C - 1'b1 |=> irq_stat_q[fbso_pkg::IRQ_SLOW];
  endproperty
  a_slow_refresh: assert property (p_slow_refresh) else $error("slow refresh not flagged");
  property p_legacy0;
    @(posedge clk_in) disable iff (reset_in)
    act_sel_q == fbso_pkg::SEL_V1_LEGACY |-> legacy_mode_out && !version2_out && !plc_mode_out;
  endproperty
  a_legacy0: assert property (p_legacy0) else $error("selector 0 not legacy v1");
  property p_v2_oct;
    @(posedge clk_in) disable iff (reset_in)
    act_sel_q == fbso_pkg::SEL_V2_OCT |-> version2_out && occupancy_out == fbso_pkg::OCC_OCT;
  endproperty
  a_v2_oct: assert property (p_v2_oct) else $error("selector 18 not v2 octuple");
  property p_ext_gate;
    @(posedge clk_in) disable iff (reset_in)
    !FEATURE_EXT |-> act_sel_q != fbso_pkg::SEL_EXT_OCT && act_sel_q != fbso_pkg::SEL_EXT_QUAD;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("extension code taken unsupported");
  property p_plc;
    @(posedge clk_in) disable iff (reset_in)
    act_sel_q == fbso_pkg::SEL_PLC_V1 |-> plc_mode_out && !version2_out;
  endproperty
  a_plc: assert property (p_plc) else $error("selector 100 not controller mode");
  property p_one_exec;
    @(posedge clk_in) disable iff (reset_in)
    legacy_mode_out |=> $onehot0(exec_q);
  endproperty
  a_one_exec: assert property (p_one_exec) else $error("legacy executed several requests");
  sequence s_legacy_refresh;
    legacy_mode_out && link_refresh_in && !apply_ev;
  endsequence
  property p_ext_byte;
    @(posedge clk_in) disable iff (reset_in)
    s_legacy_refresh |=> link_param_ext_out == $past(instruction_code_word_in[15:8])
      && instruction_code_out[15:8] == 8'h00;
  endproperty
  a_ext_byte: assert property (p_ext_byte) else $error("legacy upper byte wrong");
  property p_hold;
    @(posedge clk_in) disable iff (reset_in)
    !apply_ev |=> $stable(act_sel_q) && $stable(mode_q);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without reset");
  property p_err_ignore;
    @(posedge clk_in) disable iff (reset_in)
    rise[4] && !fault_q |=> !device_reset_out ##1 !device_reset_out;
  endproperty
  a_err_ignore: assert property (p_err_ignore) else $error("error reset without fault");
  property p_hist;
    @(posedge clk_in) disable iff (reset_in)
    rise[3] |=> fault_cnt == 4'h0;
  endproperty
  a_hist: assert property (p_hist) else $error("history not cleared");
  property p_station;
    @(posedge clk_in) disable iff (reset_in)
    station_out >= fbso_pkg::STN_MIN && station_out <= fbso_pkg::STN_MAX;
  endproperty
  a_station: assert property (p_station) else $error("station out of range");
  property p_legacy_zero;
    @(posedge clk_in) disable iff (reset_in)
    legacy_mode_out |-> instruction_code_out[15:8] == 8'h00;
  endproperty
  a_legacy_zero: assert property (p_legacy_zero) else $error("upper code byte not zero");
  property p_reject;
    @(posedge clk_in) disable iff (reset_in)
    apply_ev && !sel_ok |=> $stable(act_sel_q) && irq_stat_q[fbso_pkg::IRQ_REJECT];
  endproperty
  a_reject: assert property (p_reject) else $error("bad selector not rejected");
endmodule
`default_nettype wire

/* design/fbso_pkg.sv */
`default_nettype none
package fbso_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_ACTIVE = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_FAULT_CNT = 8'h10;
  localparam logic [7:0] OFF_FAULT_IDX = 8'h14;
  localparam logic [7:0] OFF_FAULT_DATA = 8'h18;
  // cfg fields
  localparam int unsigned CFG_SEL_LSB = 0;
  localparam int unsigned CFG_STN_LSB = 8;
  // active fields
  localparam int unsigned ACT_SEL_LSB = 0;
  localparam int unsigned ACT_STN_LSB = 8;
  localparam int unsigned ACT_MODE_LSB = 16;
  localparam int unsigned ACT_FAULT_BIT = 24;
  // ----------------------------------------------------------------
  // reset values and ranges
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [6:0] STN_RST = 7'h01;
  localparam logic [6:0] STN_MIN = 7'h01;
  localparam logic [6:0] STN_MAX = 7'h40;
  // ----------------------------------------------------------------
  // extension selector codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_V1_LEGACY = 8'h00;
  localparam logic [7:0] SEL_V1_SINGLE = 8'h01;
  localparam logic [7:0] SEL_V2_DOUBLE = 8'h0c;
  localparam logic [7:0] SEL_V2_QUAD = 8'h0e;
  localparam logic [7:0] SEL_V2_OCT = 8'h12;
  localparam logic [7:0] SEL_EXT_QUAD = 8'h18;
  localparam logic [7:0] SEL_EXT_OCT = 8'h1c;
  localparam logic [7:0] SEL_PLC_V1 = 8'h64;
  localparam logic [7:0] SEL_PLC_DOUBLE = 8'h70;
  localparam logic [7:0] SEL_PLC_QUAD = 8'h72;
  localparam logic [7:0] SEL_PLC_OCT = 8'h76;
  localparam logic [7:0] SEL_PLC_EXT_OCT = 8'h80;
  // occupancy multiple
  localparam logic [1:0] OCC_SINGLE = 2'h0;
  localparam logic [1:0] OCC_DOUBLE = 2'h1;
  localparam logic [1:0] OCC_QUAD = 2'h2;
  localparam logic [1:0] OCC_OCT = 2'h3;
  // mode word: {legacy, plc, version2, occupancy[1:0]}
  localparam int unsigned MODE_W = 5;
  localparam logic [4:0] MODE_RST = 5'h10;
  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned IRQ_REJECT = 0;
  localparam int unsigned IRQ_PENDING = 1;
  localparam int unsigned IRQ_ERR_RESET = 2;
  localparam int unsigned IRQ_HIST_CLR = 3;
  localparam int unsigned IRQ_SLOW = 4;
  localparam int unsigned IRQ_FAST = 5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real CLK_HZ = 25000000.0;
  localparam real REFRESH_MIN_MS = 1.1;
  localparam real REFRESH_MAX_MS = 141.0;
  localparam int unsigned REFRESH_MIN_CYC = int'($ceil(REFRESH_MIN_MS * CLK_HZ / 1000.0));
  localparam int unsigned REFRESH_MAX_CYC = int'($floor(REFRESH_MAX_MS * CLK_HZ / 1000.0));
  // fault records
  localparam int unsigned FAULT_DEPTH = 8;
  localparam int unsigned FAULT_W = 8;

  function automatic logic [5:0] fbso_decode(input logic [7:0] sel, input logic ext);
    // returns {valid, legacy, plc, version2, occupancy}
    logic [5:0] r;
    r = 6'h00;
    unique case (sel)
      SEL_V1_LEGACY: r = {1'b1, 1'b1, 1'b0, 1'b0, OCC_SINGLE};
      SEL_V1_SINGLE: r = {1'b1, 1'b0, 1'b0, 1'b0, OCC_SINGLE};
      SEL_V2_DOUBLE: r = {1'b1, 1'b0, 1'b0, 1'b1, OCC_DOUBLE};
      SEL_V2_QUAD: r = {1'b1, 1'b0, 1'b0, 1'b1, OCC_QUAD};
      SEL_V2_OCT: r = {1'b1, 1'b0, 1'b0, 1'b1, OCC_OCT};
      SEL_EXT_QUAD: r = {ext, 1'b0, 1'b0, 1'b1, OCC_QUAD};
      SEL_EXT_OCT: r = {ext, 1'b0, 1'b0, 1'b1, OCC_OCT};
      SEL_PLC_V1: r = {1'b1, 1'b0, 1'b1, 1'b0, OCC_SINGLE};
      SEL_PLC_DOUBLE: r = {1'b1, 1'b0, 1'b1, 1'b1, OCC_DOUBLE};
      SEL_PLC_QUAD: r = {1'b1, 1'b0, 1'b1, 1'b1, OCC_QUAD};
      SEL_PLC_OCT: r = {1'b1, 1'b0, 1'b1, 1'b1, OCC_OCT};
      SEL_PLC_EXT_OCT: r = {ext, 1'b0, 1'b1, 1'b1, OCC_OCT};
      default: r = 6'h00;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

/* design/fbso_sync3.sv */
`default_nettype none
module fbso_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // a bit moves only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule
`default_nettype wire

/* design/fbso_fault_mem.sv */
`default_nettype none
module fbso_fault_mem #(
  parameter int unsigned DEPTH = fbso_pkg::FAULT_DEPTH,
  parameter int unsigned WIDTH = fbso_pkg::FAULT_W,
  parameter int unsigned IDX_W = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic clear_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [IDX_W:0] count_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [IDX_W-1:0] ptr_q;
  logic [IDX_W-1:0] ptr_d;
  logic [IDX_W:0] cnt_q;
  logic [IDX_W:0] cnt_d;
  logic [WIDTH-1:0] rd_q;
  logic [IDX_W-1:0] age_idx;

  // index 0 is the newest record; clear beats a write in the same cycle
  always_comb begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    if (clear_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_d[i] = '0;
      end
      ptr_d = '0;
      cnt_d = '0;
    end else if (wr_in) begin
      mem_d[ptr_q] = wr_data_in;
      ptr_d = ptr_q + 1'b1;
      if (cnt_q != (IDX_W+1)'(DEPTH)) begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    age_idx = ptr_q - 1'b1 - rd_idx_in;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      ptr_q <= '0;
      cnt_q <= '0;
      rd_q <= '0;
    end else begin
      mem_q <= mem_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      rd_q <= mem_q[age_idx];
    end
  end

  assign rd_data_out = rd_q;
  assign count_out = cnt_q;
endmodule
`default_nettype wire

/* tb/fbso_master_model.sv */
`default_nettype none
module fbso_master_model #(
  parameter int unsigned PERIOD = 40
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic pause_in,
  output logic link_refresh_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run_q;
  logic [15:0] cnt_q;
  // --------------------------------
  // refresh pacing
  // --------------------------------
  // start then free-run
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      run_q <= 1'b0;
    end else if (start_in) begin
      run_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in || !run_q || cnt_q == 16'(PERIOD - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // a paused master stands for a broken line, so the station must notice the gap
  assign link_refresh_out = run_q && !pause_in && cnt_q == 16'(PERIOD - 1);
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, reset_in = 1'b1, wr = 1'b0, rd = 1'b0, pend = 1'b0;
  logic pin_rst = 1'b0, alarm = 1'b0, start = 1'b0, refresh, irq;
  logic pause = 1'b0, lgm, plm, v2m;
  logic [1:0] occ;
  logic [6:0] sout;
  logic exv, exn, exi, devrst, fact;
  logic [4:0] lv = 5'h00;
  logic [7:0] addr = 8'h00, fcode = 8'h5a, pext;
  logic [15:0] word = 16'h0000, icode;
  logic [31:0] wdata = 32'h0, rdata, prev;
  logic [31:0] exp_q[$];
  logic [6:0] st;
  logic [7:0] w;
  int n_fail = 0, n_compared = 0, cyc = 0;
  logic [7:0] sels [13] = '{8'h01, 8'h0c, 8'h0e, 8'h12, 8'h64, 8'h70, 8'h72, 8'h76,
    8'h00, 8'h18, 8'h1c, 8'h80, 8'h05};
  // 5'h1f marks a code that must be refused
  logic [4:0] modes [13] = '{5'h00, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0d, 5'h0e, 5'h0f,
    5'h10, 5'h1f, 5'h1f, 5'h1f, 5'h1f};

  fbso_master_model #(.PERIOD(40)) master (.clk_in(clk_in), .reset_in(reset_in),
    .start_in(start), .pause_in(pause), .link_refresh_out(refresh));

  fbso_station_config #(.MIN_CYC(10), .MAX_CYC(100)) DUT (.clk_in(clk_in),
    .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .inverter_reset_pin_in(pin_rst),
    .fault_alarm_pin_in(alarm), .fault_code_in(fcode), .link_refresh_in(refresh),
    .freq_set_volatile_request_in(lv[0]), .freq_set_nonvolatile_request_in(lv[1]),
    .instruction_execute_request_in(lv[2]), .instruction_code_word_in(word),
    .error_reset_request_in(lv[3]), .fault_hist_clear_in(lv[4]),
    .freq_set_volatile_exec_out(exv), .freq_set_nonvolatile_exec_out(exn),
    .instruction_exec_out(exi), .instruction_code_out(icode), .link_param_ext_out(pext),
    .legacy_mode_out(lgm), .plc_mode_out(plm), .version2_out(v2m), .occupancy_out(occ),
    .station_out(sout), .device_reset_out(devrst), .fault_active_out(fact));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd <= 1'b0;
  endtask
  // raises the chosen request levels for one cycle, stops where a pulse is visible
  task automatic rise(input logic [4:0] m);
    @(posedge clk_in);
    lv <= m;
    @(posedge clk_in);
    lv <= 5'h00;
    @(negedge clk_in);
  endtask
  task automatic apply();
    @(posedge clk_in);
    pin_rst <= 1'b1;
    repeat (2) @(posedge clk_in);
    pin_rst <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask

  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    pend <= rd;
    if (pend) check("rdata", exp_q.pop_front(), rdata);
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(9));
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    start <= 1'b1;
    prev = 32'h0010_0100;
    rreg(fbso_pkg::OFF_ACTIVE, prev); // legacy single at reset
    rreg(8'hfc, 32'h0);
    wreg(fbso_pkg::OFF_IRQ_MASK, 32'h1);
    for (int i = 0; i < 13; i++) begin
      st = 7'(1 + $urandom_range(63));
      wreg(fbso_pkg::OFF_CFG, {17'h0, st, sels[i]});
      rreg(fbso_pkg::OFF_ACTIVE, prev); // staged value not active yet
      apply();
      if (modes[i] != 5'h1f) prev = {11'h0, modes[i], 1'b0, st, sels[i]};
      rreg(fbso_pkg::OFF_ACTIVE, prev); // decoded mode
      @(negedge clk_in);
      check("irq", {31'h0, modes[i] == 5'h1f}, {31'h0, irq}); // refusal flagged
      check("mode", {27'h0, prev[20:16]}, {27'h0, lgm, plm, v2m, occ});
      check("stn", {25'h0, prev[14:8]}, {25'h0, sout}); // station in use
      wreg(fbso_pkg::OFF_IRQ_STAT, 32'h3f);
    end
    w = 8'($urandom);
    word <= {8'ha5, w};
    repeat (90) @(posedge clk_in);
    @(negedge clk_in);
    check("ext", 32'ha5, {24'h0, pext}); // upper byte as extension
    check("code", {24'h0, w}, {16'h0, icode}); // upper byte reads zero
    rise(5'h07);
    check("exec", 32'h4, {29'h0, exv, exn, exi}); // only one executed
    rise(5'h08);
    check("devrst", 32'h0, {31'h0, devrst}); // ignored without fault
    @(posedge clk_in);
    alarm <= 1'b1;
    repeat (8) @(posedge clk_in);
    rreg(fbso_pkg::OFF_FAULT_CNT, 32'h1); // one record kept
    rreg(fbso_pkg::OFF_FAULT_DATA, {24'h0, fcode}); // record content
    @(negedge clk_in);
    check("fact", 32'h1, {31'h0, fact}); // alarm raises fault
    wreg(fbso_pkg::OFF_FAULT_IDX, 32'h3);
    rreg(fbso_pkg::OFF_FAULT_IDX, 32'h3); // index held
    rreg(fbso_pkg::OFF_FAULT_DATA, 32'h0); // no record that old
    rise(5'h08);
    check("devrst", 32'h1, {31'h0, devrst}); // accepted during fault
    check("fact", 32'h0, {31'h0, fact}); // reset clears fault
    rise(5'h10);
    rreg(fbso_pkg::OFF_FAULT_CNT, 32'h0); // history erased
    rreg(fbso_pkg::OFF_FAULT_DATA, 32'h0); // record erased
    pause <= 1'b1;
    repeat (150) @(posedge clk_in);
    rreg(fbso_pkg::OFF_IRQ_STAT, 32'h1d); // missing refresh flagged
    pause <= 1'b0;
    repeat (3) @(posedge clk_in);
    print_verdict();
  end
endmodule
`default_nettype wire
